//--- src/gigapage_pkg.sv
/*
 * gigapage_pkg: constants, register map and carrier types for the
 * 1-GByte second-level page entry decoder.
 * Assumes a single clock domain and an APB register port of 32 bits.
 */
package gigapage_pkg;

   // entry field positions
   localparam int ENTRY_W        = 64;
   localparam int PAGE_SHIFT     = 30;
   localparam int RSV_TOP        = 51;
   localparam int SNOOP_BIT      = 11;
   localparam int PSIZE_BIT      = 7;
   localparam int IGNORE_ATTR_TABLE_BIT       = 6;
   localparam int EMT_HI         = 5;
   localparam int EMT_LO         = 3;
   localparam int EXEC_BIT       = 2;
   localparam int WRITE_BIT      = 1;
   localparam int READ_BIT       = 0;
   localparam logic [63:0] MID_RSV_MASK = 64'h0000_0000_3fff_f000;

   // extended memory type codes
   typedef enum logic [2:0] {
      MT_UNCACHED   = 3'h0,
      MT_WR_COMBINE = 3'h1,
      MT_WR_THROUGH = 3'h4,
      MT_WR_PROTECT = 3'h5,
      MT_WR_BACK    = 3'h6
   } mem_type_e;

   // register byte offsets
   localparam logic [11:0] CTRL_OFS   = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] DENY_OFS   = 12'h008;
   localparam logic [11:0] ADDR_LO_OFS = 12'h00c;
   localparam logic [11:0] ADDR_HI_OFS = 12'h010;

   // control register bit positions
   localparam int CTRL_SNOOP_CAP = 0;
   localparam int CTRL_ZLR_CAP   = 1;
   localparam int CTRL_EXEC_EN   = 2;
   localparam int CTRL_EMT_EN    = 3;
   localparam int CTRL_W         = 4;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
   localparam logic [31:0] DENY_RESET = 32'h0000_0000;
   localparam logic [31:0] DENY_ONE   = 32'h0000_0001;

   typedef struct packed {
      logic [63:0] entry;
      logic [29:0] page_offset;
      logic        translation;
      logic        has_pasid;
      logic        rd;
      logic        wr;
      logic        ex;
      logic        zero_len;
      logic        no_snoop_attr;
      logic        nested;
      logic        coherent;
   } gp_req_s;

   typedef struct packed {
      logic [63:0] phys_addr;
      logic        next_level;
      logic        rsvd_fault;
      logic        read_deny;
      logic        write_deny;
      logic        exec_deny;
      logic        emt_fault;
      logic        snoop;
      logic        nonsnoop_n;
      logic        emt_valid;
      logic [2:0]  extended_memory_type;
      logic        use_attr_table;
   } gp_rsp_s;

   localparam int RSP_FLAGS_W = 12;

endpackage

//--- src/gigapage_entry_decoder.sv
/*
 * gigapage_entry_decoder: checks one 64-bit second-level entry mapping a
 * 1-GByte page against one request and returns the decoded result a
 * cycle later; capability and context bits are set over APB.
 * Assumes requests are presented as one-cycle REQ_VALID pulses in the
 * CORE_CLK domain and that the walker supplies the fetched entry.
 */
// The implementer's own choices: the address map and the APB register port.
// What this block does
// [RULE_01] page base address comes from entry bits host_address_width-1 down to 30
// [RULE_02] without snoop control capability, entry bit 11 is reserved, must be zero
// [RULE_03] force_snoop set makes untranslated no-PASID requests snoop, whatever attributes
// [RULE_04] no-PASID translation requests return force_snoop as the non-snooped bit
// [RULE_05] PASID requests ignore force_snoop; untranslated ones always snoop
// [RULE_06] PASID translation requests always return the non-snooped bit as one
// [RULE_07] page_size_flag must be one; zero means entry points to next directory
// [RULE_08] ignore_attr_table only for nested coherent PASID requests with memory type enabled
// [RULE_09] extended_memory_type codes 0,1,4,5,6 valid, used only when enabled and nested
// [RULE_10] execute denied when execute enable set and fetch_permitted bit is zero
// [RULE_11] write denied when store_permitted bit is zero
// [RULE_12] read denied when load_allowed bit is zero
// [RULE_13] with zero-length read support, zero-length reads skip read check if W or X
// [RULE_14] bits 63, 61:52, 10:8 ignored; nonzero reserved bits raise a fault
`timescale 1ns/10ps
module gigapage_entry_decoder #(
   parameter int HOST_ADDRESS_WIDTH = 48
) (
   // clock and reset
   input  wire logic                   CORE_CLK,
   input  wire logic                   RST,
   // apb slave
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [11:0]            PADDR,
   input  wire logic [31:0]            PWDATA,
   output logic      [31:0]            PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   // request in
   input  wire logic                   REQ_VALID,
   input  wire gigapage_pkg::gp_req_s  REQ,
   // result out
   output logic                        RSP_VALID,
   output gigapage_pkg::gp_rsp_s       RSP
);
   import gigapage_pkg::*;

   // bits HOST_ADDRESS_WIDTH..51 of the entry are reserved
   localparam logic [63:0] HI_RSV_MASK =
      ((64'h1 << (RSV_TOP + 1)) - 64'h1) & ~((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1);
   localparam logic [63:0] BASE_MASK =
      ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1) & ~((64'h1 << PAGE_SHIFT) - 64'h1);

   logic [CTRL_W-1:0] ctrl;
   logic [31:0]       deny_count;
   gp_rsp_s           rsp_q;
   logic              rsp_valid_q;

   // control bits
   wire logic snoop_control_capability    = ctrl[CTRL_SNOOP_CAP];
   wire logic zero_length_read_support    = ctrl[CTRL_ZLR_CAP];
   wire logic second_level_execute_enable = ctrl[CTRL_EXEC_EN];
   wire logic extended_memory_type_enable = ctrl[CTRL_EMT_EN];

   // entry fields
   wire logic [63:0] entry            = REQ.entry;
   wire logic        page_size_flag   = entry[PSIZE_BIT];
   wire logic        force_snoop_bit  = entry[SNOOP_BIT];
   wire logic        ignore_attr_table = entry[IGNORE_ATTR_TABLE_BIT];
   wire logic [2:0]  extended_memory_type = entry[EMT_HI:EMT_LO];
   wire logic        fetch_permitted  = entry[EXEC_BIT];
   wire logic        store_permitted  = entry[WRITE_BIT];
   wire logic        load_allowed     = entry[READ_BIT];

   // reserved checks; ignored bits never enter any term
   wire logic hi_rsv   = |(entry & HI_RSV_MASK);           // RULE_14
   wire logic mid_rsv  = |(entry & MID_RSV_MASK);          // RULE_14
   wire logic snp_rsv  = force_snoop_bit & ~snoop_control_capability; // RULE_02
   wire logic leaf     = page_size_flag;                   // RULE_07
   wire logic rsvd_fault = leaf & (hi_rsv | mid_rsv | snp_rsv);

   // physical address of the access
   wire logic [63:0] page_base = entry & BASE_MASK;        // RULE_01
   wire logic [63:0] phys_addr =
      page_base | {34'h0, REQ.page_offset};

   // permission checks
   wire logic exec_deny = REQ.ex & second_level_execute_enable
                          & ~fetch_permitted;              // RULE_10
   wire logic write_deny = REQ.wr & ~store_permitted;      // RULE_11
   wire logic zlr_exempt = zero_length_read_support & REQ.zero_len
                           & (fetch_permitted | store_permitted); // RULE_13
   wire logic read_deny = REQ.rd & ~load_allowed & ~zlr_exempt; // RULE_12

   // snoop handling
   wire logic force_snoop = force_snoop_bit & snoop_control_capability;
   wire logic snoop_nopasid = force_snoop | ~REQ.no_snoop_attr; // RULE_03
   wire logic snoop = REQ.has_pasid | snoop_nopasid;        // RULE_05
   wire logic nonsnoop_n = REQ.has_pasid ? 1'b1             // RULE_06
                                         : force_snoop;     // RULE_04

   // extended memory type
   wire logic emt_applies = extended_memory_type_enable & REQ.has_pasid
                            & REQ.nested & REQ.coherent;    // RULE_08
   logic emt_code_ok;
   always_comb begin
      case (extended_memory_type)
         MT_UNCACHED, MT_WR_COMBINE, MT_WR_THROUGH,
         MT_WR_PROTECT, MT_WR_BACK: emt_code_ok = 1'b1;     // RULE_09
         default:                  emt_code_ok = 1'b0;
      endcase
   end
   wire logic emt_fault = leaf & emt_applies & ~emt_code_ok; // RULE_09

   // result assembly; a non-leaf entry grants nothing here
   gp_rsp_s next_rsp;
   always_comb begin
      next_rsp = '0;
      next_rsp.next_level = ~leaf;                           // RULE_07
      if (leaf) begin
         next_rsp.phys_addr  = phys_addr;
         next_rsp.rsvd_fault = rsvd_fault;
         next_rsp.read_deny  = read_deny;
         next_rsp.write_deny = write_deny;
         next_rsp.exec_deny  = exec_deny;
         next_rsp.emt_fault  = emt_fault;
         next_rsp.snoop      = ~REQ.translation & snoop;
         next_rsp.nonsnoop_n = REQ.translation & nonsnoop_n;
         next_rsp.emt_valid  = emt_applies & emt_code_ok;
         if (emt_applies) begin
            next_rsp.extended_memory_type = extended_memory_type;
            next_rsp.use_attr_table = ~ignore_attr_table;    // RULE_08
         end
      end
   end

   wire logic any_deny = next_rsp.rsvd_fault | next_rsp.read_deny
                         | next_rsp.write_deny | next_rsp.exec_deny
                         | next_rsp.emt_fault;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         rsp_q       <= '0;
         rsp_valid_q <= 1'b0;
      end else begin
         rsp_valid_q <= REQ_VALID;
         if (REQ_VALID) begin
            rsp_q <= next_rsp;
         end
      end
   end

   assign RSP_VALID = rsp_valid_q;
   assign RSP       = rsp_q;

   // apb decode: zero wait states
   wire logic apb_access = PSEL & PENABLE;
   wire logic hit_ctrl   = (PADDR == CTRL_OFS);
   wire logic hit_status = (PADDR == STATUS_OFS);
   wire logic hit_deny   = (PADDR == DENY_OFS);
   wire logic hit_alo    = (PADDR == ADDR_LO_OFS);
   wire logic hit_ahi    = (PADDR == ADDR_HI_OFS);
   wire logic mapped = hit_ctrl | hit_status | hit_deny | hit_alo | hit_ahi;
   wire logic ctrl_wr  = apb_access & PWRITE & hit_ctrl;
   wire logic deny_clr = apb_access & PWRITE & hit_deny;
   wire logic deny_inc = REQ_VALID & any_deny;

   wire logic [31:0] status_word =
      {{(32-RSP_FLAGS_W){1'b0}}, rsp_q.next_level, rsp_q.rsvd_fault,
       rsp_q.read_deny, rsp_q.write_deny, rsp_q.exec_deny,
       rsp_q.emt_fault, rsp_q.snoop, rsp_q.nonsnoop_n,
       rsp_q.emt_valid, rsp_q.extended_memory_type};

   wire logic [31:0] rd_mux =
      hit_ctrl   ? {{(32-CTRL_W){1'b0}}, ctrl} :
      hit_status ? status_word :
      hit_deny   ? deny_count :
      hit_alo    ? rsp_q.phys_addr[31:0] :
      hit_ahi    ? rsp_q.phys_addr[63:32] : 32'h0000_0000;

   // a same-cycle clear and increment leave the count at one, so no denial is lost
   wire logic [31:0] next_deny_count =
      deny_inc ? (deny_clr ? DENY_ONE : deny_count + DENY_ONE) :
      deny_clr ? DENY_RESET : deny_count;

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         ctrl       <= CTRL_RESET;
         deny_count <= DENY_RESET;
      end else begin
         deny_count <= next_deny_count;
         if (ctrl_wr) begin
            ctrl <= PWDATA[CTRL_W-1:0];
         end
      end
   end

   always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
         PRDATA <= 32'h0000_0000;
      end else if (PSEL & ~PENABLE & ~PWRITE) begin
         PRDATA <= rd_mux;
      end
   end

   assign PREADY  = 1'b1;
   assign PSLVERR = apb_access & ~mapped;

endmodule

//--- dv/gigapage_entry_decoder_monitor.sv
/* decoder port checker: result timing and decode relations.
   assumes one clock domain; bound into every decoder instance. */
`timescale 1ns/10ps
module gigapage_entry_decoder_monitor #(
   parameter int HOST_ADDRESS_WIDTH = 48
) (
   // clock and reset
   input wire logic                  CORE_CLK,
   input wire logic                  RST,
   // apb
   input wire logic                  PSEL,
   input wire logic                  PENABLE,
   input wire logic                  PREADY,
   // request and result
   input wire logic                  REQ_VALID,
   input wire gigapage_pkg::gp_req_s REQ,
   input wire logic                  RSP_VALID,
   input wire gigapage_pkg::gp_rsp_s RSP
);
   import gigapage_pkg::*;
   gp_req_s          q;
   wire logic [63:0] amask = ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1) & ~64'h3fff_ffff;
   wire logic        leaf = RSP_VALID && q.entry[7];
   always_ff @(posedge CORE_CLK) q <= REQ;
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   a_rsp_next_cycle : assert property (
      REQ_VALID |=> RSP_VALID) else $error("no result after request");
   a_rsp_has_cause : assert property (
      RSP_VALID |-> $past(REQ_VALID)) else $error("stray result");
   a_rsp_holds : assert property (
      !REQ_VALID |=> $stable(RSP)) else $error("result changed");
   a_next_level : assert property (
      RSP_VALID && !q.entry[7] |-> RSP.next_level && RSP.phys_addr == 0)
      else $error("directory pointer not flagged");
   a_page_base : assert property (
      leaf |-> RSP.phys_addr == ((q.entry & amask) | 64'(q.page_offset)))
      else $error("bad page address");
   a_write_deny : assert property (
      leaf |-> RSP.write_deny == (q.wr && !q.entry[1]))
      else $error("bad write check");
   a_read_deny : assert property (
      leaf && !q.zero_len |-> RSP.read_deny == (q.rd && !q.entry[0]))
      else $error("bad read check");
   a_pasid_snoop : assert property (
      leaf && q.has_pasid && !q.translation |-> RSP.snoop)
      else $error("pasid request not snooped");
   a_pasid_nsn : assert property (
      leaf && q.has_pasid && q.translation |-> RSP.nonsnoop_n)
      else $error("pasid completion allows no-snoop");
   a_mid_rsv : assert property (
      leaf && |(q.entry & MID_RSV_MASK) |-> RSP.rsvd_fault)
      else $error("reserved bits not faulted");
   a_apb_ready : assert property (
      PSEL && PENABLE |-> PREADY) else $error("apb stalled");
endmodule
bind gigapage_entry_decoder gigapage_entry_decoder_monitor #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) u_mon (
   .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
   .PREADY(PREADY), .REQ_VALID(REQ_VALID), .REQ(REQ),
   .RSP_VALID(RSP_VALID), .RSP(RSP));

//--- dv/gigapage_requester.sv
/* requester model: an i/o device issuing one request per call.
   assumes the decoder takes REQ on the edge after REQ_VALID rises. */
`timescale 1ns/10ps
module gigapage_requester (
   // clock
   input wire logic              CORE_CLK,
   // request out
   output logic                  REQ_VALID,
   output gigapage_pkg::gp_req_s REQ
);
   import gigapage_pkg::*;
   initial begin
      REQ_VALID = 1'b0;
      REQ = '0;
   end
   // after the strobe the data lines show junk, not the old request
   task automatic issue(input gp_req_s r);
      @(posedge CORE_CLK);
      REQ_VALID <= 1'b1;
      REQ <= r;
      @(posedge CORE_CLK);
      REQ_VALID <= 1'b0;
      REQ <= ~r;
   endtask
endmodule

//--- dv/tb_gigapage_entry_decoder.sv
/* self-checking bench: random requests under all control settings.
   assumes zero-wait apb and a result one cycle after each request. */
`timescale 1ns/10ps
module tb_gigapage_entry_decoder;
   import gigapage_pkg::*;
   localparam int HOST_ADDRESS_WIDTH = 40;
   localparam logic [63:0] AM = ((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1) & ~64'h3fff_ffff;
   localparam logic [63:0] RM = (64'h000f_ffff_ffff_ffff
      & ~((64'h1 << HOST_ADDRESS_WIDTH) - 64'h1)) | MID_RSV_MASK;
   logic        CORE_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [11:0] PADDR = '0;
   logic [31:0] PWDATA = '0, PRDATA, rd;
   logic        PREADY, PSLVERR, REQ_VALID, RSP_VALID, err;
   logic [3:0]  ctrl;
   gp_req_s     REQ;
   gp_rsp_s     RSP;
   int          fail_count = 0, n_checks = 0, cyc = 0, exp_deny = 0;
   gp_req_s     fault_req;
   always #10 CORE_CLK = ~CORE_CLK;
   gigapage_entry_decoder #(.HOST_ADDRESS_WIDTH(HOST_ADDRESS_WIDTH)) i_gigapage_entry_decoder (
      .CORE_CLK(CORE_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .REQ_VALID(REQ_VALID),
      .REQ(REQ), .RSP_VALID(RSP_VALID), .RSP(RSP));
   gigapage_requester i_gigapage_requester (
      .CORE_CLK(CORE_CLK), .REQ_VALID(REQ_VALID), .REQ(REQ));
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge CORE_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk_word(string n, logic [63:0] e, logic [63:0] s);
      n_checks++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic chk_rsp(gp_rsp_s e);
      n_checks++;
      if (RSP !== e) begin
         fail_count++;
         $display("BAD rsp exp %h got %h", e, RSP);
      end
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge CORE_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      @(posedge CORE_CLK);
      while (PREADY !== 1'b1) @(posedge CORE_CLK);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   function automatic gp_rsp_s model(gp_req_s q);
      gp_rsp_s r;
      logic [63:0] e;
      logic s;
      r = '0;
      e = q.entry;
      s = e[11] & ctrl[0];
      if (!e[7]) begin
         r.next_level = 1'b1;
         return r;
      end
      r.phys_addr = (e & AM) | 64'(q.page_offset);
      r.rsvd_fault = (|(e & RM)) | (e[11] & !ctrl[0]);
      r.exec_deny = q.ex & ctrl[2] & !e[2];
      r.write_deny = q.wr & !e[1];
      r.read_deny = q.rd & !e[0] & !(ctrl[1] & q.zero_len & (e[1] | e[2]));
      if (!q.translation) r.snoop = q.has_pasid | s | !q.no_snoop_attr;
      else r.nonsnoop_n = q.has_pasid | s;
      if (ctrl[3] & q.has_pasid & q.nested & q.coherent) begin
         r.extended_memory_type = e[5:3];
         r.use_attr_table = !e[6];
         r.emt_valid = e[5:3] inside {0, 1, 4, 5, 6};
         r.emt_fault = !r.emt_valid;
      end
      return r;
   endfunction
   task automatic one_req();
      logic [127:0] raw;
      gp_req_s r;
      gp_rsp_s x;
      raw = {$urandom, $urandom, $urandom, $urandom};
      r = raw[$bits(gp_req_s)-1:0];
      if (raw[127]) r.entry = r.entry & ~RM;
      if (raw[126:125] != 2'h0) r.entry[7] = 1'b1;
      x = model(r);
      if (x.rsvd_fault | x.read_deny | x.write_deny | x.exec_deny
          | x.emt_fault) exp_deny++;
      i_gigapage_requester.issue(r);
      @(negedge CORE_CLK);
      chk_word("rsp_valid", 64'h1, 64'(RSP_VALID));
      chk_rsp(x);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk_word("status", 64'(x[12:1]), 64'(rd));
      apb(1'b0, ADDR_HI_OFS, 32'h0);
      chk_word("addr_hi", 64'(x.phys_addr[63:32]), 64'(rd));
      apb(1'b0, ADDR_LO_OFS, 32'h0);
      chk_word("addr_lo", 64'(x.phys_addr[31:0]), 64'(rd));
   endtask
   initial begin
      void'($urandom(32'h8ec0));
      ctrl = CTRL_RESET;
      repeat (12) @(posedge CORE_CLK);
      RST <= 1'b0;
      apb(1'b0, CTRL_OFS, 32'h0);
      chk_word("ctrl_reset", 64'(CTRL_RESET), 64'(rd));
      apb(1'b1, 12'h014, 32'hffff_ffff);
      chk_word("unmapped_err", 64'h1, 64'(err));
      for (int c = 0; c < 16; c++) begin
         ctrl = c[3:0];
         apb(1'b1, CTRL_OFS, 32'(ctrl));
         apb(1'b0, CTRL_OFS, 32'h0);
         chk_word("ctrl", 64'(ctrl), 64'(rd));
         chk_word("ctrl_err", 64'h0, 64'(err));
         apb(1'b1, DENY_OFS, 32'h1);
         apb(1'b0, DENY_OFS, 32'h0);
         chk_word("deny_clear", 64'(DENY_RESET), 64'(rd));
         exp_deny = 0;
         repeat (24) one_req();
         apb(1'b0, DENY_OFS, 32'h0);
         chk_word("deny_count", 64'(exp_deny), 64'(rd));
      end
      // faulting request taken on the same edge as the count clear
      fault_req = '0;
      fault_req.entry = 64'h0000_0000_0000_1080;
      fork
         apb(1'b1, DENY_OFS, 32'h0);
         begin
            @(posedge CORE_CLK);
            i_gigapage_requester.issue(fault_req);
         end
      join
      apb(1'b0, DENY_OFS, 32'h0);
      chk_word("deny_collide", 64'(DENY_ONE), 64'(rd));
      give_verdict();
   end
endmodule
